// ===== rtl/afepmc_power_ctrl.sv
// power modes, clock stabilizer, channel timing and serial registers
`timescale 1ns/1ps
// What this block does
// - stabilizer on regenerates 50% duty clock
// - stabilizer can be switched off
// - eight-cycle relock, data flagged invalid
// - power-down pin high enters power-down
// - power-down puts output drivers high-Z
// - power-down kills reference, buffer, PLL, bias
// - 375 us wake from full power-down
// - wake time scales with time down
// - standby pin high enters standby
// - standby keeps references, drivers high-Z
// - serial per-channel power-down, serial standby for the whole block
// - serial standby may keep PLL running
// - serial standby resumes within 2 us
// - start count delays channel power-up
// - stop count switches channel off
// - counts measured from transmit trigger
// - analog enabled before digital
// - selectable LNA bias, default mid-high
module afepmc_power_ctrl import afepmc_pkg::*; #(
    parameter int unsigned PD_WAKE_CYCLES = PD_WAKE_CYCLES_DEF
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_power_down_pin,
    input wire logic i_standby_pin,
    input wire logic i_transmit_trigger,
    input wire logic i_rate_change,
    input wire logic i_spi_sclk,
    input wire logic i_spi_csn,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    output logic o_ref_en,
    output logic o_refbuf_en,
    output logic o_pll_en,
    output logic o_bias_en,
    output logic o_lvds_oe,
    output logic o_data_valid,
    output logic o_dcs_enable,
    output logic o_dcs_locked,
    output logic [7:0] o_lna_bias,
    output logic [NUM_CH-1:0] o_chan_analog_en,
    output logic [NUM_CH-1:0] o_chan_digital_en
);
    localparam logic [WAKE_W-1:0] PD_WAKE_MAX = WAKE_W'(PD_WAKE_CYCLES);

    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic sclk_q;
    logic trig_q;
    logic pd_s;
    logic sb_pin_s;
    logic sclk_rise;
    logic sclk_fall;
    logic trig_rise;
    logic spi_active;
    logic [SPI_FRAME_BITS-2:0] spi_shift;
    logic [SPI_FRAME_BITS-1:0] next_frame;
    logic [4:0] spi_bits;
    logic [SPI_HDR_BITS-1:0] spi_hdr;
    logic [7:0] spi_tx;
    logic [7:0] rd_data;
    logic wr_en;
    logic [SPI_ADDR_BITS-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] lna_bias;
    logic [7:0] pwr_timing;
    logic [7:0] chan_pd;
    logic [7:0] mode_ctrl;
    logic [7:0] status;
    logic [7:0] start_cnt [NUM_CH];
    logic [7:0] stop_cnt [NUM_CH];
    logic [CNT_W-1:0] sample_count;
    afepmc_pwr_type state;
    afepmc_pwr_type next_state;
    logic [WAKE_W-1:0] wake_cnt;
    logic [WAKE_W-1:0] down_cnt;
    logic standby_pin_req;
    logic pll_keep;
    logic dcs_en;
    logic dcs_q;
    logic [3:0] relock_cnt;
    logic dll_ok;
    logic chan_run;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
            sclk_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            pin_meta <= {i_spi_sdi, i_spi_csn, i_spi_sclk, i_transmit_trigger,
                         i_standby_pin, i_power_down_pin};
            pin_sync <= pin_meta;
            sclk_q <= pin_sync[PIN_SCLK];
            trig_q <= pin_sync[PIN_TRIG];
        end
    end

    assign pd_s = pin_sync[PIN_PD];
    assign sb_pin_s = pin_sync[PIN_SB];
    assign sclk_rise = pin_sync[PIN_SCLK] && !sclk_q;
    assign sclk_fall = !pin_sync[PIN_SCLK] && sclk_q;
    assign trig_rise = pin_sync[PIN_TRIG] && !trig_q;
    assign spi_active = !pin_sync[PIN_CSN];
    assign next_frame = {spi_shift, pin_sync[PIN_SDI]};
    assign wr_en = spi_active && sclk_rise && (spi_bits == SPI_LAST_BIT) &&
                   !spi_hdr[SPI_HDR_BITS-1];
    assign wr_addr = spi_hdr[SPI_ADDR_BITS-1:0];
    assign wr_data = next_frame[7:0];

    // serial port shifter, readback on falling edges
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            spi_shift <= '0;
            spi_bits <= 5'h00;
            spi_hdr <= '0;
            spi_tx <= 8'h00;
            o_spi_sdo_oe <= 1'b0;
        end else if (!spi_active) begin
            spi_bits <= 5'h00;
            o_spi_sdo_oe <= 1'b0;
        end else if (sclk_rise) begin
            spi_shift <= next_frame[SPI_FRAME_BITS-2:0];
            spi_bits <= (spi_bits == SPI_LAST_BIT) ? 5'h00 : spi_bits + 5'h01;
            if (spi_bits == SPI_HDR_LAST) begin
                spi_hdr <= next_frame[SPI_HDR_BITS-1:0];
                spi_tx <= rd_data;
                o_spi_sdo_oe <= next_frame[SPI_HDR_BITS-1];
            end
            if (spi_bits == SPI_LAST_BIT) begin
                o_spi_sdo_oe <= 1'b0;
            end
        end else if (sclk_fall && o_spi_sdo_oe && spi_bits != SPI_HDR_LAST + 5'h01) begin
            spi_tx <= {spi_tx[6:0], 1'b0};
        end
    end

    assign o_spi_sdo = spi_tx[7];

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            lna_bias <= LNA_BIAS_RESET;
            pwr_timing <= PWR_TIMING_RESET;
            chan_pd <= CHAN_PD_RESET;
            mode_ctrl <= MODE_CTRL_RESET;
        end else if (wr_en) begin
            case (wr_addr)
                ADDR_LNA_BIAS: lna_bias <= wr_data & LNA_BIAS_MASK;
                ADDR_PWR_TIMING: pwr_timing <= wr_data;
                ADDR_CHAN_PD: chan_pd <= wr_data;
                ADDR_MODE_CTRL: mode_ctrl <= wr_data & MODE_CTRL_MASK;
                default: ;
            endcase
        end
    end

    assign o_lna_bias = lna_bias;
    assign status = {4'h0, state == PWR_STANDBY, state == PWR_DOWN, o_dcs_locked, o_data_valid};

    always_comb begin
        rd_data = 8'h00;
        case (next_frame[SPI_ADDR_BITS-1:0])
            ADDR_LNA_BIAS: rd_data = lna_bias;
            ADDR_PWR_TIMING: rd_data = pwr_timing;
            ADDR_CHAN_PD: rd_data = chan_pd;
            ADDR_MODE_CTRL: rd_data = mode_ctrl;
            ADDR_STATUS: rd_data = status;
            default: rd_data = 8'h00;
        endcase
        for (int k = 0; k < NUM_CH; k++) begin
            if (next_frame[SPI_ADDR_BITS-1:0] == ADDR_START_BASE + 15'(k)) begin
                rd_data = start_cnt[k];
            end
            if (next_frame[SPI_ADDR_BITS-1:0] == ADDR_STOP_BASE + 15'(k)) begin
                rd_data = stop_cnt[k];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sample_count <= '0;
        end else if (trig_rise) begin
            sample_count <= '0;
        end else if (sample_count != CNT_MAX) begin
            sample_count <= sample_count + 9'h001;
        end
    end

    assign standby_pin_req = sb_pin_s || mode_ctrl[MODE_STANDBY_PIN_BIT];

    always_comb begin
        next_state = state;
        case (state)
            PWR_ACTIVE: begin
                if (pd_s) next_state = PWR_DOWN;
                else if (standby_pin_req) next_state = PWR_STANDBY;
            end
            PWR_DOWN: begin
                if (!pd_s) next_state = standby_pin_req ? PWR_STANDBY : PWR_WAKE;
            end
            PWR_STANDBY: begin
                if (pd_s) next_state = PWR_DOWN;
                else if (!standby_pin_req) next_state = PWR_WAKE;
            end
            PWR_WAKE: begin
                if (pd_s) next_state = PWR_DOWN;
                else if (standby_pin_req) next_state = PWR_STANDBY;
                else if (wake_cnt == '0) next_state = PWR_ACTIVE;
            end
            default: next_state = PWR_DOWN;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= PWR_WAKE;
        end else begin
            state <= next_state;
        end
    end

    // time spent down, capped at full wake
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            down_cnt <= '0;
        end else if (state != PWR_DOWN) begin
            down_cnt <= '0;
        end else if (down_cnt < PD_WAKE_MAX) begin
            down_cnt <= down_cnt + 17'h00001;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_cnt <= PD_WAKE_MAX;
        end else if (state == PWR_DOWN && next_state == PWR_WAKE) begin
            wake_cnt <= down_cnt;
        end else if (state == PWR_STANDBY && next_state == PWR_WAKE) begin
            wake_cnt <= STANDBY_PIN_WAKE_CYCLES;
        end else if (state == PWR_WAKE && wake_cnt != '0) begin
            wake_cnt <= wake_cnt - 17'h00001;
        end
    end

    assign pll_keep = mode_ctrl[MODE_KEEP_PLL_BIT] && mode_ctrl[MODE_STANDBY_PIN_BIT] && !sb_pin_s;
    assign chan_run = (state == PWR_ACTIVE) || (state == PWR_WAKE);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ref_en <= 1'b0;
            o_refbuf_en <= 1'b0;
            o_pll_en <= 1'b0;
            o_bias_en <= 1'b0;
            o_lvds_oe <= 1'b0;
            o_data_valid <= 1'b0;
        end else begin
            o_ref_en <= next_state != PWR_DOWN;
            o_refbuf_en <= next_state != PWR_DOWN;
            o_pll_en <= (next_state == PWR_ACTIVE) || (next_state == PWR_WAKE) ||
                        (next_state == PWR_STANDBY && pll_keep);
            o_bias_en <= (next_state == PWR_ACTIVE) || (next_state == PWR_WAKE);
            o_lvds_oe <= (next_state == PWR_ACTIVE) || (next_state == PWR_WAKE);
            o_data_valid <= (next_state == PWR_ACTIVE) && dll_ok;
        end
    end

    assign dcs_en = mode_ctrl[MODE_DCS_BIT];
    assign dll_ok = !dcs_en || (relock_cnt == 4'h0);

    // relock after rate change, stabilizer enable or leaving power-down
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            relock_cnt <= DLL_RELOCK_CYCLES;
            dcs_q <= 1'b0;
        end else begin
            dcs_q <= dcs_en;
            if (i_rate_change || (dcs_en && !dcs_q) ||
                (state == PWR_DOWN && next_state != PWR_DOWN)) begin
                relock_cnt <= DLL_RELOCK_CYCLES;
            end else if (relock_cnt != 4'h0) begin
                relock_cnt <= relock_cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dcs_enable <= 1'b0;
            o_dcs_locked <= 1'b0;
        end else begin
            o_dcs_enable <= dcs_en;
            o_dcs_locked <= dcs_en && (relock_cnt == 4'h0);
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        afepmc_chan_if chif ();

        always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
                start_cnt[g] <= COUNT_RESET;
                stop_cnt[g] <= COUNT_RESET;
            end else if (wr_en) begin
                if (wr_addr == ADDR_START_BASE + 15'(g)) start_cnt[g] <= wr_data;
                if (wr_addr == ADDR_STOP_BASE + 15'(g)) stop_cnt[g] <= wr_data;
            end
        end

        assign chif.count = sample_count;
        assign chif.start = {1'b0, start_cnt[g]};
        assign chif.stop = {1'b0, stop_cnt[g]};
        assign chif.warmup = {1'b0, pwr_timing};
        assign chif.run = chan_run && !chan_pd[g];
        assign o_chan_analog_en[g] = chif.analog_en;
        assign o_chan_digital_en[g] = chif.digital_en;

        afepmc_chan_seq u_seq (
            .i_mclk(i_mclk),
            .i_resetn(i_resetn),
            .ch(chif.seq)
        );
    end

    sequence s_pd_off;
        !o_lvds_oe && !o_ref_en && !o_refbuf_en && !o_pll_en && !o_bias_en;
    endsequence
    sequence s_standby_pin_off;
        !o_lvds_oe && o_ref_en && !o_bias_en && !o_pll_en;
    endsequence
    sequence s_relock_hold;
        (!o_dcs_locked && !(o_data_valid && o_dcs_enable)) [*8];
    endsequence

    property p_pd_hiz;
        @(posedge i_mclk) disable iff (!i_resetn)
        pd_s |=> s_pd_off;
    endproperty
    a_pd_hiz: assert property (p_pd_hiz) else $error("power-down left drivers on");

    property p_standby_pin_pin;
        @(posedge i_mclk) disable iff (!i_resetn)
        (sb_pin_s && !pd_s) |=> s_standby_pin_off;
    endproperty
    a_standby_pin_pin: assert property (p_standby_pin_pin) else $error("standby rails wrong");

    property p_relock;
        @(posedge i_mclk) disable iff (!i_resetn)
        i_rate_change |-> ##2 s_relock_hold;
    endproperty
    a_relock: assert property (p_relock) else $error("lock before relock time");

    property p_pd_wake_scale;
        @(posedge i_mclk) disable iff (!i_resetn)
        (state == PWR_DOWN && next_state == PWR_WAKE) |=> wake_cnt == $past(down_cnt);
    endproperty
    a_pd_wake_scale: assert property (p_pd_wake_scale) else $error("wake not scaled");

    property p_standby_pin_wake;
        @(posedge i_mclk) disable iff (!i_resetn)
        (state == PWR_STANDBY && next_state == PWR_WAKE) |=> wake_cnt == STANDBY_PIN_WAKE_CYCLES;
    endproperty
    a_standby_pin_wake: assert property (p_standby_pin_wake) else $error("standby wake length");

    property p_wake_done;
        @(posedge i_mclk) disable iff (!i_resetn)
        (state == PWR_WAKE && wake_cnt == '0 && !pd_s && !standby_pin_req) |=> state == PWR_ACTIVE;
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("wake did not finish");

    property p_keep_pll;
        @(posedge i_mclk) disable iff (!i_resetn)
        (state == PWR_STANDBY && next_state == PWR_STANDBY && pll_keep) |=> o_pll_en;
    endproperty
    a_keep_pll: assert property (p_keep_pll) else $error("pll dropped in standby");

    property p_chan_pd;
        @(posedge i_mclk) disable iff (!i_resetn)
        ##1 ((o_chan_analog_en & $past(chan_pd)) == 8'h00);
    endproperty
    a_chan_pd: assert property (p_chan_pd) else $error("disabled channel powered");

    property p_trig_restart;
        @(posedge i_mclk) disable iff (!i_resetn)
        trig_rise |=> sample_count == '0 ##1 sample_count == 9'h001;
    endproperty
    a_trig_restart: assert property (p_trig_restart) else $error("count not restarted");
endmodule : afepmc_power_ctrl

// ===== rtl/afepmc_pkg.sv
// constants and types shared by the power-mode control block
package afepmc_pkg;
    localparam int NUM_CH = 8;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] CNT_MAX = 9'h1FF;
    // serial frame: read flag, 15-bit address, 8-bit data, msb first
    localparam int SPI_FRAME_BITS = 24;
    localparam int SPI_HDR_BITS = 16;
    localparam int SPI_ADDR_BITS = 15;
    localparam logic [4:0] SPI_LAST_BIT = 5'h17;
    localparam logic [4:0] SPI_HDR_LAST = 5'h0F;
    // register map
    localparam logic [14:0] ADDR_CHAN_PD = 15'h0008;
    localparam logic [14:0] ADDR_MODE_CTRL = 15'h0009;
    localparam logic [14:0] ADDR_STATUS = 15'h000A;
    localparam logic [14:0] ADDR_LNA_BIAS = 15'h0012;
    localparam logic [14:0] ADDR_PWR_TIMING = 15'h0112;
    localparam logic [14:0] ADDR_START_BASE = 15'h0113;
    localparam logic [14:0] ADDR_STOP_BASE = 15'h011B;
    localparam logic [7:0] LNA_BIAS_RESET = 8'h02;
    localparam logic [7:0] LNA_BIAS_MASK = 8'h03;
    localparam logic [7:0] PWR_TIMING_RESET = 8'h00;
    localparam logic [7:0] CHAN_PD_RESET = 8'h00;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h04;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h07;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam int MODE_STANDBY_PIN_BIT = 0;
    localparam int MODE_KEEP_PLL_BIT = 1;
    localparam int MODE_DCS_BIT = 2;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_PD_BIT = 2;
    localparam int STAT_SB_BIT = 3;
    // pin sampling vector
    localparam int PIN_PD = 0;
    localparam int PIN_SB = 1;
    localparam int PIN_TRIG = 2;
    localparam int PIN_SCLK = 3;
    localparam int PIN_CSN = 4;
    localparam int PIN_SDI = 5;
    localparam int PIN_W = 6;
    localparam logic [PIN_W-1:0] PIN_RESET = 6'h10;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [3:0] DLL_RELOCK_CYCLES = 4'h8;
    localparam int PD_WAKE_US = 375;
    localparam int STANDBY_PIN_WAKE_US = 2;
    localparam int WAKE_W = 17;
    localparam int PD_WAKE_CYCLES_DEF = (PD_WAKE_US * 1000) / CLK_PERIOD_NS;
    localparam logic [WAKE_W-1:0] STANDBY_PIN_WAKE_CYCLES =
        WAKE_W'((STANDBY_PIN_WAKE_US * 1000) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_DOWN,
        PWR_STANDBY,
        PWR_WAKE
    } afepmc_pwr_type;
endpackage : afepmc_pkg

// ===== rtl/afepmc_chan_if.sv
// per-channel timing controls and enables between top and sequencer
`timescale 1ns/1ps
interface afepmc_chan_if import afepmc_pkg::*; ();
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] stop;
    logic [CNT_W-1:0] warmup;
    logic run;
    logic analog_en;
    logic digital_en;

    modport seq (
        input count,
        input start,
        input stop,
        input warmup,
        input run,
        output analog_en,
        output digital_en
    );
    modport ctrl (
        output count,
        output start,
        output stop,
        output warmup,
        output run,
        input analog_en,
        input digital_en
    );
endinterface : afepmc_chan_if

// ===== rtl/afepmc_chan_seq.sv
// one channel's start/stop window and analog-then-digital power-up
`timescale 1ns/1ps
module afepmc_chan_seq import afepmc_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_resetn,
    afepmc_chan_if.seq ch
);
    logic in_window;
    logic [CNT_W:0] digital_at;

    assign in_window = ch.run && (ch.count >= ch.start) &&
                       ((ch.stop == '0) || (ch.count < ch.stop));
    assign digital_at = {1'b0, ch.start} + {1'b0, ch.warmup};

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ch.analog_en <= 1'b0;
        end else begin
            ch.analog_en <= in_window;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ch.digital_en <= 1'b0;
        end else begin
            ch.digital_en <= in_window && ch.analog_en && ({1'b0, ch.count} >= digital_at);
        end
    end

    property p_start_delay;
        @(posedge i_mclk) disable iff (!i_resetn)
        ch.analog_en |-> ($past(ch.count) >= $past(ch.start));
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("channel on before start");

    property p_stop_off;
        @(posedge i_mclk) disable iff (!i_resetn)
        (ch.stop != '0 && ch.count >= ch.stop) |=> !ch.analog_en && !ch.digital_en;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("channel on after stop");

    property p_analog_first;
        @(posedge i_mclk) disable iff (!i_resetn)
        $rose(ch.digital_en) |-> ch.analog_en && $past(ch.analog_en);
    endproperty
    a_analog_first: assert property (p_analog_first) else $error("digital before analog");
endmodule : afepmc_chan_seq

// ===== tb/afepmc_ctrl_model.sv
// controller model: serial frames and power-timing programming
`timescale 1ns/1ps
module afepmc_ctrl_model import afepmc_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_spi_sdo,
    output logic o_spi_sclk,
    output logic o_spi_csn,
    output logic o_spi_sdi
);
    initial begin
        o_spi_sclk = 1'b0;
        o_spi_csn = 1'b1;
        o_spi_sdi = 1'b0;
    end
    // one frame, msb first, sclk four clocks low then five high per bit
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [23:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(posedge i_mclk);
        o_spi_csn <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge i_mclk);
            o_spi_sdi <= f[i];
            o_spi_sclk <= 1'b0;
            repeat (4) @(posedge i_mclk);
            // read data is taken as sclk rises, before the block drops its enable
            if (i < 8) q = {q[6:0], i_spi_sdo};
            o_spi_sclk <= 1'b1;
            repeat (4) @(posedge i_mclk);
        end
        @(posedge i_mclk);
        o_spi_sclk <= 1'b0;
        repeat (4) @(posedge i_mclk);
        o_spi_csn <= 1'b1;
        // released line shows the inverse of its last bit
        o_spi_sdi <= ~f[0];
        repeat (4) @(posedge i_mclk);
    endtask : xfer
    task automatic prog_chan(input int ch, input logic [7:0] warm, st, sp);
        logic [7:0] q;
        xfer(1'b0, ADDR_PWR_TIMING, warm, q);
        xfer(1'b0, ADDR_START_BASE + 15'(ch), st, q);
        xfer(1'b0, ADDR_STOP_BASE + 15'(ch), sp, q);
    endtask : prog_chan
endmodule : afepmc_ctrl_model

// ===== tb/tb.sv
// self-checking bench for the power-mode control block
`timescale 1ns/1ps
module tb import afepmc_pkg::*;;
    logic mclk, rstn, pd, sb, trig, rate, sclk, csn, sdi, sdo, sdo_oe;
    logic ref_en, rbuf, pll, bias, oe, dv, den, dlk;
    logic [7:0] lna, ae, de;
    int failures = 0;
    int cmp_count = 0;
    int oe_cycles = 0;

    afepmc_power_ctrl #(.PD_WAKE_CYCLES(50)) u_afepmc_power_ctrl (
        .i_mclk(mclk), .i_resetn(rstn), .i_power_down_pin(pd), .i_standby_pin(sb),
        .i_transmit_trigger(trig), .i_rate_change(rate), .i_spi_sclk(sclk),
        .i_spi_csn(csn), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe),
        .o_ref_en(ref_en), .o_refbuf_en(rbuf), .o_pll_en(pll), .o_bias_en(bias),
        .o_lvds_oe(oe), .o_data_valid(dv), .o_dcs_enable(den), .o_dcs_locked(dlk),
        .o_lna_bias(lna), .o_chan_analog_en(ae), .o_chan_digital_en(de));
    // released sdo reads as the inverse of what the block last drove
    afepmc_ctrl_model u_afepmc_ctrl_model (.i_mclk(mclk), .i_spi_sdo(sdo_oe ? sdo : ~sdo),
        .o_spi_sclk(sclk), .o_spi_csn(csn), .o_spi_sdi(sdi));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        if (sdo_oe === 1'b1) begin
            oe_cycles++;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : tick
    task automatic wait_dv(input int lim, output int n);
        n = 0;
        while (dv !== 1'b1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_dv
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_afepmc_ctrl_model.xfer(1'b0, a, d, q);
    endtask : wr
    task automatic t_regs;
        logic [7:0] q;
        u_afepmc_ctrl_model.xfer(1'b1, ADDR_LNA_BIAS, 8'h00, q);
        check(q, 8'h02);
        check(16'(oe_cycles), 16'h0048);
        check(lna, 8'h02);
        u_afepmc_ctrl_model.xfer(1'b1, 15'h0050, 8'h00, q);
        check(q, 8'h00);
        wr(ADDR_LNA_BIAS, 8'h01);
        check(lna, 8'h01);
        check(16'(oe_cycles), 16'h0090);
        u_afepmc_ctrl_model.xfer(1'b1, ADDR_LNA_BIAS, 8'h00, q);
        check(q, 8'h01);
        $display("regs done");
    endtask : t_regs
    task automatic t_pdown;
        int n;
        int e;
        for (int d = 20; d <= 80; d *= 2) begin
            e = (d > 50) ? 50 : d;
            @(posedge mclk);
            pd <= 1'b1;
            tick(4);
            check({oe, ref_en, rbuf, pll, bias, dv}, 6'h00);
            repeat (d - 4) @(posedge mclk);
            pd <= 1'b0;
            wait_dv(300, n);
            check(n >= e && n <= e + 10, 1'b1);
            check({oe, ref_en, rbuf, pll, bias}, 5'h1F);
        end
        $display("power-down done");
    endtask : t_pdown
    task automatic t_standby_pin;
        int n;
        @(posedge mclk);
        sb <= 1'b1;
        tick(4);
        check({oe, ref_en, rbuf, pll, bias}, 5'h0C);
        @(posedge mclk);
        sb <= 1'b0;
        wait_dv(700, n);
        check(n >= 500 && n <= 510, 1'b1);
        wr(ADDR_MODE_CTRL, 8'h07);
        tick(2);
        check({oe, ref_en, pll, bias}, 4'h6);
        wr(ADDR_MODE_CTRL, 8'h05);
        tick(2);
        check({oe, ref_en, pll}, 3'h2);
        wr(ADDR_MODE_CTRL, 8'h04);
        wait_dv(700, n);
        check(n >= 480 && n <= 510, 1'b1);
        wr(ADDR_CHAN_PD, 8'h02);
        tick(2);
        check({ae[2], ae[1], de[1]}, 3'h4);
        wr(ADDR_CHAN_PD, 8'h00);
        $display("standby done");
    endtask : t_standby_pin
    task automatic t_stab;
        int lo_lk;
        int lo_dv;
        wr(ADDR_MODE_CTRL, 8'h00);
        tick(2);
        check({den, dlk}, 2'h0);
        wr(ADDR_MODE_CTRL, 8'h04);
        tick(20);
        check({den, dlk, dv}, 3'h7);
        lo_lk = 0;
        lo_dv = 0;
        @(posedge mclk);
        rate <= 1'b1;
        @(posedge mclk);
        rate <= 1'b0;
        repeat (16) begin
            @(negedge mclk);
            lo_lk += (dlk === 1'b0);
            lo_dv += (dv === 1'b0);
        end
        check(lo_lk, 8);
        check(lo_dv, 8);
        $display("stabilizer done");
    endtask : t_stab
    task automatic t_chan;
        int ar;
        int dr;
        int af;
        u_afepmc_ctrl_model.prog_chan(0, 8'h05, 8'h0A, 8'h1E);
        repeat (2) begin
            ar = 0;
            dr = 0;
            af = 0;
            @(posedge mclk);
            trig <= 1'b1;
            @(posedge mclk);
            trig <= 1'b0;
            for (int k = 2; k <= 60; k++) begin
                @(negedge mclk);
                if (ar == 0 && ae[0] === 1'b1) ar = k;
                if (dr == 0 && de[0] === 1'b1) dr = k;
                if (ar != 0 && af == 0 && ae[0] === 1'b0) af = k;
            end
            check(ar >= 11 && ar <= 17, 1'b1);
            check(dr - ar, 5);
            check(af - ar, 20);
        end
        $display("channel done");
    endtask : t_chan
    task automatic test_done;
        $display("checks=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        int n;
        rstn = 1'b0;
        pd = 1'b0;
        sb = 1'b0;
        trig = 1'b0;
        rate = 1'b0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        wait_dv(200, n);
        check(den, 1'b1);
        check(dv, 1'b1);
        t_regs();
        t_pdown();
        t_standby_pin();
        t_stab();
        t_chan();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        test_done();
    end
endmodule : tb
